// ==== verilog/mswk_wakeup.sv ====
`timescale 1ns/1ps
`include "mswk_params.svh"

// Contract
// [RULE_01] One internal 8-bit wake flag register records which source woke the sleeping core.
// [RULE_02] Flags are raised by key scan, external keyboard, mouse, three timers, serial port, clock and two inputs.
// [RULE_03] A wake event resumes the core through a vectored branch with no reset and no oscillator wait.
// [RULE_04] Receive logic assembles serial keyboard or mouse bits into whole bytes for the core.
// [RULE_05] The receive logic keeps capturing during sleep or halt and loses no data; the code drops a byte that finds 17 unread and sets o_rx_err.
// [RULE_06] The clock block can be programmed to issue periodic wake requests, after which the core may sleep again.
// [RULE_07] A modem ring detect arriving at the serial port can serve as a wake source.
// [RULE_08] Monitored general I/O lines raise a wake event on any change of state.
// [RULE_09] Each flag is set by its event and held until software clears it.
module mswk_wakeup
  import mswk_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_kscan_evt,
  input wire logic i_tmr_evt0,
  input wire logic i_tmr_evt1,
  input wire logic i_tmr_evt2,
  input wire logic i_uart_evt,
  input wire logic i_ring_det,
  input wire logic i_ring_en,
  input wire logic i_rtc_tick,
  input wire logic [15:0] i_rtc_period,
  input wire logic i_rtc_wake_en,
  input wire logic i_ext_in0,
  input wire logic i_ext_in1,
  input wire logic [`MSWK_GPIO_W-1:0] i_gpio,
  input wire logic [`MSWK_GPIO_W-1:0] i_gpio_mon,
  input wire logic [`MSWK_FLAG_W-1:0] i_wake_en,
  input wire logic [`MSWK_FLAG_W-1:0] i_flag_clr,
  input wire logic i_ext_clr,
  input wire logic i_core_sleep,
  input wire logic i_wake_ack,
  input wire logic i_kb_clk,
  input wire logic i_kb_data,
  input wire logic i_ms_clk,
  input wire logic i_ms_data,
  input wire logic i_kb_rd,
  input wire logic i_ms_rd,
  output logic [`MSWK_FLAG_W-1:0] o_wake_flags,
  output logic [1:0] o_ext_flags,
  output logic o_core_run,
  output logic o_wake_branch,
  output logic [15:0] o_wake_vector,
  output logic o_asleep,
  output logic o_kb_valid,
  output logic [`MSWK_BYTE_W-1:0] o_kb_byte,
  output logic o_ms_valid,
  output logic [`MSWK_BYTE_W-1:0] o_ms_byte,
  output logic o_rx_err
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [`MSWK_FLAG_W-1:0] flags;
    logic [1:0] ext_flags;
    logic [1:0] ext_prev;
    logic [`MSWK_GPIO_W-1:0] gpio_prev;
    logic ring_prev;
    logic [15:0] rtc_cnt;
    mswk_pwr_t pwr;
    logic branch;
    logic [1:0] kclk_prev;
    mswk_rx_t [1:0] rx_st;
    logic [1:0][3:0] rx_bit;
    logic [1:0][7:0] rx_sh;
    logic [1:0] rx_par;
    logic rx_err;
  } mswk_st_t;

  mswk_st_t st_q;
  mswk_st_t st_d;
  logic [1:0] rx_push;
  logic [1:0] rx_ready;
  logic [1:0] sclk;
  logic [1:0] sdat;
  logic [`MSWK_FLAG_W-1:0] evt;
  logic ext_evt0;
  logic ext_evt1;
  logic gpio_evt;
  logic rtc_evt;
  logic any_wake;

  assign sclk = {i_ms_clk, i_kb_clk};
  assign sdat = {i_ms_data, i_kb_data};

  function automatic logic rise(input logic now, input logic prev);
    return now && !prev;
  endfunction

  // ----------------------------------------
  // Wake sources
  // ----------------------------------------
  assign rtc_evt = i_rtc_tick && i_rtc_wake_en && (st_q.rtc_cnt == '0); // [RULE_06]
  assign gpio_evt = |((i_gpio ^ st_q.gpio_prev) & i_gpio_mon); // [RULE_08]
  assign ext_evt0 = rise(i_ext_in0, st_q.ext_prev[0]) | gpio_evt;
  assign ext_evt1 = rise(i_ext_in1, st_q.ext_prev[1]);

  always_comb begin
    evt = '0;
    evt[`MSWK_BIT_KSCAN] = i_kscan_evt; // [RULE_02]
    evt[`MSWK_BIT_EXTKB] = rx_push[0];
    evt[`MSWK_BIT_MOUSE] = rx_push[1];
    evt[`MSWK_BIT_TMR0] = i_tmr_evt0;
    evt[`MSWK_BIT_TMR1] = i_tmr_evt1;
    evt[`MSWK_BIT_TMR2] = i_tmr_evt2;
    evt[`MSWK_BIT_UART] = i_uart_evt | (i_ring_en && rise(i_ring_det, st_q.ring_prev)); // [RULE_07]
    evt[`MSWK_BIT_RTC] = rtc_evt;
  end

  assign any_wake = |(st_q.flags & i_wake_en) | (|st_q.ext_flags);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.branch = 1'b0;
    // Set beats clear so an event in the clearing cycle survives
    st_d.flags = (st_q.flags & ~i_flag_clr) | evt; // [RULE_01] [RULE_09]
    st_d.ext_flags = (st_q.ext_flags & {2{~i_ext_clr}}) | {ext_evt1, ext_evt0}; // [RULE_02] [RULE_09]
    st_d.ext_prev = {i_ext_in1, i_ext_in0};
    st_d.gpio_prev = i_gpio;
    st_d.ring_prev = i_ring_det;
    if (i_rtc_tick) begin
      st_d.rtc_cnt = (st_q.rtc_cnt == '0) ? i_rtc_period : st_q.rtc_cnt - 16'h0001; // [RULE_06]
    end
    case (st_q.pwr)
      MSWK_RUN: begin
        if (i_core_sleep && !any_wake) begin
          st_d.pwr = MSWK_SLEEP;
        end
      end
      MSWK_SLEEP: begin
        // Core resumes at the vector without reset or oscillator wait
        if (any_wake) begin
          st_d.pwr = MSWK_WAKE; // [RULE_03]
          st_d.branch = 1'b1;
        end
      end
      MSWK_WAKE: begin
        if (i_wake_ack) begin
          st_d.pwr = MSWK_RUN; // [RULE_06]
        end
      end
      default: st_d.pwr = MSWK_RUN;
    endcase
    // Serial receivers run regardless of the power state
    st_d.kclk_prev = sclk;
    for (int k = 0; k < 2; k++) begin
      if (!sclk[k] && st_q.kclk_prev[k]) begin // [RULE_05]
        case (st_q.rx_st[k])
          MSWK_RX_IDLE: begin
            if (!sdat[k]) begin
              st_d.rx_st[k] = MSWK_RX_DATA;
              st_d.rx_bit[k] = '0;
              st_d.rx_par[k] = 1'b0;
            end
          end
          MSWK_RX_DATA: begin
            st_d.rx_sh[k] = {sdat[k], st_q.rx_sh[k][7:1]}; // [RULE_04]
            st_d.rx_par[k] = st_q.rx_par[k] ^ sdat[k];
            st_d.rx_bit[k] = st_q.rx_bit[k] + 4'h1;
            if (st_q.rx_bit[k] == 4'h7) begin
              st_d.rx_st[k] = MSWK_RX_PAR;
            end
          end
          MSWK_RX_PAR: begin
            st_d.rx_par[k] = st_q.rx_par[k] ^ sdat[k];
            st_d.rx_st[k] = MSWK_RX_STOP;
          end
          MSWK_RX_STOP: begin
            st_d.rx_st[k] = MSWK_RX_IDLE;
            // Odd parity, stop high, and room in the buffer; else flagged
            if (!st_q.rx_par[k] || !sdat[k] || !rx_ready[k]) begin
              st_d.rx_err = 1'b1; // [RULE_05]
            end
          end
          default: st_d.rx_st[k] = MSWK_RX_IDLE;
        endcase
      end
    end
    if (i_srst) begin
      st_d = '0;
      st_d.pwr = MSWK_RUN;
      st_d.flags = `MSWK_FLAGS_RST;
      st_d.kclk_prev = 2'h3;
      // GPIO, input and ring edge detectors start at the pin level, so leaving reset makes no false edge
      st_d.gpio_prev = i_gpio;
      st_d.ext_prev = {i_ext_in1, i_ext_in0};
      st_d.ring_prev = i_ring_det;
    end
  end

  always_comb begin
    for (int k = 0; k < 2; k++) begin
      rx_push[k] = !sclk[k] && st_q.kclk_prev[k] && (st_q.rx_st[k] == MSWK_RX_STOP)
                   && st_q.rx_par[k] && sdat[k] && rx_ready[k]; // [RULE_04]
    end
  end

  always_ff @(posedge i_clk) begin
    st_q <= st_d;
  end

  // ----------------------------------------
  // Byte buffers
  // ----------------------------------------
  // Limitation: a device that outruns 17 unread bytes is reported, not stalled
  mswk_fifo #(.WIDTH(`MSWK_BYTE_W), .DEPTH(`MSWK_FIFO_DEPTH)) u_kb_fifo (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_in_valid(rx_push[0]),
    .o_in_ready(rx_ready[0]),
    .i_in_data(st_q.rx_sh[0]),
    .o_out_valid(o_kb_valid),
    .i_out_ready(i_kb_rd),
    .o_out_data(o_kb_byte)
  );

  mswk_fifo #(.WIDTH(`MSWK_BYTE_W), .DEPTH(`MSWK_FIFO_DEPTH)) u_ms_fifo (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_in_valid(rx_push[1]),
    .o_in_ready(rx_ready[1]),
    .i_in_data(st_q.rx_sh[1]),
    .o_out_valid(o_ms_valid),
    .i_out_ready(i_ms_rd),
    .o_out_data(o_ms_byte)
  );

  assign o_wake_flags = st_q.flags;
  assign o_ext_flags = st_q.ext_flags;
  assign o_asleep = (st_q.pwr == MSWK_SLEEP);
  assign o_core_run = (st_q.pwr != MSWK_SLEEP);
  assign o_wake_branch = st_q.branch; // [RULE_03]
  assign o_wake_vector = `MSWK_VECTOR_DEF;
  assign o_rx_err = st_q.rx_err;
endmodule

// ==== verilog/mswk_params.svh ====
`ifndef MSWK_PARAMS_SVH
`define MSWK_PARAMS_SVH

// ----------------------------------------
// Wake flag bit positions
// ----------------------------------------
`define MSWK_BIT_KSCAN 0
`define MSWK_BIT_EXTKB 1
`define MSWK_BIT_MOUSE 2
`define MSWK_BIT_TMR0 3
`define MSWK_BIT_TMR1 4
`define MSWK_BIT_TMR2 5
`define MSWK_BIT_UART 6
`define MSWK_BIT_RTC 7

// ----------------------------------------
// Widths, depths, reset values
// ----------------------------------------
`define MSWK_FLAG_W 8
`define MSWK_BYTE_W 8
`define MSWK_FIFO_DEPTH 16
`define MSWK_FLAGS_RST 8'h00
`define MSWK_GPIO_W 8
`define MSWK_VECTOR_DEF 16'h0033

`endif

// ==== verilog/mswk_pkg.sv ====
package mswk_pkg;
  typedef enum logic [1:0] {
    MSWK_RUN,
    MSWK_SLEEP,
    MSWK_WAKE
  } mswk_pwr_t;

  typedef enum logic [1:0] {
    MSWK_RX_IDLE,
    MSWK_RX_DATA,
    MSWK_RX_PAR,
    MSWK_RX_STOP
  } mswk_rx_t;
endpackage

// ==== verilog/mswk_fifo.sv ====
`timescale 1ns/1ps
module mswk_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [WIDTH-1:0] rd_data;
    logic rd_valid;
  } mswk_fifo_st_t;

  mswk_fifo_st_t st_q;
  mswk_fifo_st_t st_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push;
  logic pop;

  // Output word sits in a register; memory is one entry behind it
  assign o_in_ready = (st_q.count < (AW+1)'(DEPTH));
  assign o_out_valid = st_q.rd_valid;
  assign o_out_data = st_q.rd_data;
  assign push = i_in_valid && o_in_ready;
  assign pop = st_q.rd_valid && i_out_ready;

  always_comb begin
    logic load;
    load = 1'b0;
    st_d = st_q;
    if (push) begin
      st_d.wr_ptr = st_q.wr_ptr + 1'b1;
    end
    // Refill the output register from memory when it is empty or drained
    if ((!st_q.rd_valid || pop) && (st_q.count != '0)) begin
      load = 1'b1;
    end
    if (load) begin
      st_d.rd_data = mem_q[st_q.rd_ptr];
      st_d.rd_valid = 1'b1;
      st_d.rd_ptr = st_q.rd_ptr + 1'b1;
    end else if (pop) begin
      st_d.rd_valid = 1'b0;
    end
    st_d.count = st_q.count + (AW+1)'(push) - (AW+1)'(load);
    if (i_srst) begin
      st_d = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    st_q <= st_d;
    if (push) begin
      mem_q[st_q.wr_ptr] <= i_in_data;
    end
  end
endmodule

// ==== verif/mswk_link_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Serial keyboard or mouse sender
// ----------------------------------------
module mswk_link_model (
  input wire logic i_clk,
  output logic o_lclk,
  output logic o_ldata
);
  // Link clock rests high between frames; data rests high like a pulled-up line
  initial begin
    o_lclk = 1'b1;
    o_ldata = 1'b1;
  end
  // Start 0, data LSB first, odd parity, stop 1; bad flips parity
  task automatic send(input logic [7:0] b, input logic bad, input int hp);
    logic [10:0] f;
    f = {1'b1, ~^b ^ bad, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      o_ldata = f[i];
      repeat (hp) @(negedge i_clk);
      o_lclk = 1'b0;
      repeat (hp) @(negedge i_clk);
      o_lclk = 1'b1;
    end
    o_ldata = 1'b1;
  endtask
endmodule

// ==== verif/mswk_wakeup_chk.sv ====
`timescale 1ns/1ps
module mswk_wakeup_chk (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_kscan_evt,
  input wire logic i_ext_in0,
  input wire logic i_core_sleep,
  input wire logic i_wake_ack,
  input wire logic i_kb_rd,
  input wire logic [7:0] i_wake_en,
  input wire logic [7:0] i_flag_clr,
  input wire logic [7:0] o_wake_flags,
  input wire logic [1:0] o_ext_flags,
  input wire logic o_core_run,
  input wire logic o_wake_branch,
  input wire logic [15:0] o_wake_vector,
  input wire logic o_asleep,
  input wire logic o_kb_valid,
  input wire logic [7:0] o_kb_byte
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  logic wake_q;
  logic pend;
  logic run;
  assign pend = |(o_wake_flags & i_wake_en) || (|o_ext_flags);
  assign run = !o_asleep && !o_wake_branch && !wake_q;
  // Tracks the wake state until the core acknowledges vector entry
  always_ff @(posedge i_clk) begin
    if (i_srst) wake_q <= 1'b0;
    else if (o_wake_branch || wake_q) wake_q <= !i_wake_ack;
  end
  sequence s_branch;
    o_wake_branch && o_core_run && o_wake_vector == 16'h0033 ##1 !o_wake_branch;
  endsequence
  property p_kscan_set;
    i_kscan_evt |=> o_wake_flags[0];
  endproperty
  a_kscan_set: assert property (p_kscan_set) else $error("kscan flag not set");
  property p_flag_hold;
    o_wake_flags[0] && !i_flag_clr[0] |=> o_wake_flags[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
  property p_flag_clr;
    i_flag_clr[0] && !i_kscan_evt |=> !o_wake_flags[0];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
  property p_sleep_enter;
    run && i_core_sleep && !pend |=> o_asleep && !o_core_run;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");
  property p_sleep_refuse;
    run && pend |=> !o_asleep;
  endproperty
  a_sleep_refuse: assert property (p_sleep_refuse) else $error("slept with flag pending");
  property p_wake;
    o_asleep && pend |=> s_branch;
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake branch");
  property p_wake_hold;
    (o_wake_branch || wake_q) && !i_wake_ack |=> o_core_run && !o_asleep;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("left wake early");
  property p_ext_edge;
    $rose(i_ext_in0) |=> o_ext_flags[0];
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("ext flag not set");
  property p_kb_hold;
    o_kb_valid && !i_kb_rd |=> o_kb_valid && $stable(o_kb_byte);
  endproperty
  a_kb_hold: assert property (p_kb_hold) else $error("kb byte dropped");
endmodule
bind mswk_wakeup mswk_wakeup_chk chk_u (.*);

// ==== verif/mswk_wakeup_tb_top.sv ====
`timescale 1ns/1ps
module mswk_wakeup_tb_top;
  logic i_clk, i_srst, i_ring_det, i_ring_en, i_rtc_tick, i_rtc_wake_en, i_ext_in0, i_ext_in1, i_ext_clr;
  logic i_core_sleep, i_wake_ack, i_kb_rd, i_ms_rd, o_core_run, o_wake_branch, o_asleep;
  logic o_kb_valid, o_ms_valid, o_rx_err;
  logic [4:0] ev;
  logic [15:0] i_rtc_period, o_wake_vector;
  logic [7:0] i_gpio, i_gpio_mon, i_wake_en, i_flag_clr, o_wake_flags, o_kb_byte, o_ms_byte;
  logic [1:0] o_ext_flags;
  logic kb_clk, kb_data, ms_clk, ms_data;
  int failures, cmp_count;
  mswk_wakeup dut_u (.*, .i_kscan_evt(ev[0]), .i_tmr_evt0(ev[1]), .i_tmr_evt1(ev[2]), .i_tmr_evt2(ev[3]),
    .i_uart_evt(ev[4]), .i_kb_clk(kb_clk), .i_kb_data(kb_data), .i_ms_clk(ms_clk), .i_ms_data(ms_data));
  mswk_link_model kb_u (.i_clk(i_clk), .o_lclk(kb_clk), .o_ldata(kb_data));
  mswk_link_model ms_u (.i_clk(i_clk), .o_lclk(ms_clk), .o_ldata(ms_data));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Polls at falling edges, so a one-cycle pulse is never missed
  task automatic wait_hi(ref logic s, input int n);
    repeat (n) begin
      if (s === 1'b1) return;
      cyc(1);
    end
    failures++;
    wrap_up();
  endtask
  task automatic do_reset();
    i_srst = 1'b1;
    cyc(16);
    i_srst = 1'b0;
    cyc(1);
  endtask
  task automatic clr_all();
    i_flag_clr = 8'hff;
    i_ext_clr = 1'b1;
    cyc(1);
    i_flag_clr = 8'h00;
    i_ext_clr = 1'b0;
    cyc(1);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_src();
    int pos [5] = '{0, 3, 4, 5, 6};
    chk("reset", {o_wake_flags, o_ext_flags, o_core_run, o_asleep, o_kb_valid, o_rx_err}, 14'h0008);
    for (int i = 0; i < 5; i++) begin
      ev = 5'h01 << i;
      i_flag_clr = 8'h01 << pos[i];
      cyc(1);
      ev = 5'h00;
      i_flag_clr = 8'h00;
      cyc(2);
      chk("flag set", o_wake_flags, 8'h01 << pos[i]);
      clr_all();
      chk("flag clr", o_wake_flags, 8'h00);
    end
    i_ring_det = 1'b1;
    cyc(2);
    chk("ring off", o_wake_flags, 8'h00);
    i_ring_det = 1'b0;
    i_ring_en = 1'b1;
    cyc(1);
    i_ring_det = 1'b1;
    cyc(2);
    chk("ring", o_wake_flags, 8'h40);
    clr_all();
  endtask
  task automatic t_ext();
    i_gpio_mon = 8'h10;
    i_gpio = 8'h01;
    cyc(2);
    chk("unmonitored", o_ext_flags, 2'h0);
    i_gpio = 8'h11;
    i_ext_in1 = 1'b1;
    cyc(2);
    chk("gpio", o_ext_flags, 2'h3);
    clr_all();
    i_ext_in0 = 1'b1;
    cyc(2);
    chk("ext0", o_ext_flags, 2'h1);
    clr_all();
  endtask
  task automatic t_rtc();
    i_rtc_wake_en = 1'b1;
    // Counter leaves reset at zero, so the first tick wakes, then every third
    for (int j = 1; j <= 4; j++) begin
      i_rtc_tick = 1'b1;
      cyc(1);
      i_rtc_tick = 1'b0;
      cyc(2);
      chk("rtc", o_wake_flags[7], j == 1 || j == 4);
      clr_all();
    end
  endtask
  task automatic t_sleep();
    i_wake_en = 8'h01;
    ev = 5'h01;
    cyc(1);
    ev = 5'h00;
    i_core_sleep = 1'b1;
    cyc(1);
    i_core_sleep = 1'b0;
    cyc(1);
    chk("refused", o_asleep, 1'b0);
    clr_all();
    i_core_sleep = 1'b1;
    cyc(1);
    i_core_sleep = 1'b0;
    cyc(1);
    chk("asleep", {o_asleep, o_core_run}, 2'h2);
    kb_u.send(8'h3c, 1'b0, 6);
    cyc(4);
    chk("slept on", {o_asleep, o_wake_flags[1]}, 2'h3);
    ev = 5'h01;
    cyc(1);
    ev = 5'h00;
    wait_hi(o_wake_branch, 4);
    chk("branch", {o_core_run, o_wake_vector}, 17'h10033);
    i_wake_ack = 1'b1;
    cyc(1);
    i_wake_ack = 1'b0;
    chk("kept byte", {o_kb_valid, o_kb_byte}, 9'h13c);
    i_kb_rd = 1'b1;
    cyc(1);
    i_kb_rd = 1'b0;
    clr_all();
  endtask
  task automatic t_mouse();
    ms_u.send(8'h81, 1'b0, 3);
    wait_hi(o_ms_valid, 8);
    chk("ms byte", {o_wake_flags[2], o_ms_byte}, 9'h181);
    i_ms_rd = 1'b1;
    cyc(1);
    i_ms_rd = 1'b0;
    ms_u.send(8'h5a, 1'b1, 3);
    cyc(8);
    chk("parity", {o_ms_valid, o_rx_err}, 2'h1);
  endtask
  // Output stage stalls while the link fills 16 words plus the output register
  task automatic t_fifo();
    chk("reset again", {o_wake_flags, o_ext_flags, o_rx_err}, 11'h000);
    for (int i = 0; i < 18; i++) begin
      kb_u.send(8'h40 + 8'(i), 1'b0, 3);
      cyc(4);
      chk("overflow", o_rx_err, i == 17);
    end
    for (int i = 0; i < 17; i++) begin
      wait_hi(o_kb_valid, 8);
      chk("fifo", o_kb_byte, 8'h40 + 8'(i));
      i_kb_rd = 1'b1;
      cyc(1);
      i_kb_rd = 1'b0;
      cyc(1);
    end
    cyc(2);
    chk("empty", o_kb_valid, 1'b0);
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    failures = 0;
    cmp_count = 0;
    {i_ring_det, i_ring_en, i_rtc_tick, i_rtc_wake_en, i_ext_in0, i_ext_in1, i_ext_clr, ev} = '0;
    {i_core_sleep, i_wake_ack, i_kb_rd, i_ms_rd, i_gpio, i_gpio_mon, i_flag_clr, i_wake_en} = '0;
    i_rtc_period = 16'h0002;
    do_reset();
    t_src();
    t_ext();
    t_rtc();
    t_sleep();
    t_mouse();
    do_reset();
    t_fifo();
    wrap_up();
  end
endmodule
